// file: lcm_pkg.sv
`default_nettype none
package lcm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the APB word grid
  localparam logic [11:0] LCM_CTRL_OFS = 12'h000;   // Mode and chain options
  localparam logic [11:0] LCM_TABLE_OFS = 12'h004;  // Look-up table contents
  localparam logic [11:0] LCM_STATUS_OFS = 12'h008; // Live cell outputs

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int LCM_CTRL_W = 6;          // Implemented control bits
  localparam int LCM_MODE_LSB = 0;        // Mode, two bits
  localparam int LCM_CIN_SEL_BIT = 2;     // Carry-in replaces third input
  localparam int LCM_CASC_EN_BIT = 3;     // Cascade chain in use
  localparam int LCM_PACKED_BIT = 4;      // Register fed apart from table
  localparam int LCM_CASC_OR_BIT = 5;     // Cascade joins by OR, else AND
  localparam logic [5:0] LCM_CTRL_RST = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Table register fields
  localparam int LCM_TABLE_W = 16;        // Four-input table, 16 entries
  localparam int LCM_CARRY_LSB = 8;       // Carry table base in arithmetic
  localparam logic [15:0] LCM_TABLE_RST = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Status register fields
  localparam int LCM_ST_REG_BIT = 0;
  localparam int LCM_ST_COMB_BIT = 1;
  localparam int LCM_ST_CARRY_BIT = 2;
  localparam int LCM_ST_CASC_BIT = 3;
  localparam int LCM_ST_MODE_LSB = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Operating modes
  typedef enum logic [1:0] {
    LCM_NORMAL = 2'b00,
    LCM_ARITH = 2'b01,
    LCM_COUNTER = 2'b10,
    LCM_SPARE = 2'b11
  } lcm_mode_e;

endpackage : lcm_pkg
`default_nettype wire

// file: lcm_logic_cell.sv
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module lcm_logic_cell (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic first_operand_in,
  input wire logic second_operand_in,
  input wire logic third_table_in,
  input wire logic fourth_table_in,
  input wire logic carry_in,
  input wire logic cascade_in,
  input wire logic clock_enable_in,
  input wire logic cluster_sync_clear,
  input wire logic cluster_sync_load,
  output logic carry_out,
  output logic cascade_out,
  output logic comb_out,
  output logic reg_out
);
  import lcm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration state and APB answer
  logic [LCM_CTRL_W-1:0] ctrl;         // Mode and chain options
  logic [LCM_TABLE_W-1:0] table_mask;  // Table contents
  logic [LCM_CTRL_W-1:0] next_ctrl;
  logic [LCM_TABLE_W-1:0] next_table_mask;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic wr_fire;                        // Write completes this edge
  logic addr_hit;                       // Address maps to a register

  // Decoded control fields
  lcm_mode_e mode;
  logic cin_sel;
  logic casc_en;
  logic packed_reg;
  logic casc_or;

  assign mode = lcm_mode_e'(ctrl[LCM_MODE_LSB +: 2]);
  assign cin_sel = ctrl[LCM_CIN_SEL_BIT];
  assign casc_en = ctrl[LCM_CASC_EN_BIT];
  assign packed_reg = ctrl[LCM_PACKED_BIT];
  assign casc_or = ctrl[LCM_CASC_OR_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, then pready for a single cycle
  always_comb begin
    wr_fire = psel && penable && pready && pwrite;
    addr_hit = (paddr == LCM_CTRL_OFS) || (paddr == LCM_TABLE_OFS) ||
               (paddr == LCM_STATUS_OFS);
    next_ctrl = ctrl;
    next_table_mask = table_mask;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    // Answer on the second access cycle; drop right after handshake
    next_pready = psel && penable && !pready;
    if (next_pready) begin
      next_pslverr = !addr_hit;
      next_prdata = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          LCM_CTRL_OFS: begin
            next_prdata[LCM_CTRL_W-1:0] = ctrl;
          end
          LCM_TABLE_OFS: begin
            next_prdata[LCM_TABLE_W-1:0] = table_mask;
          end
          LCM_STATUS_OFS: begin
            // Live view of the cell's own outputs
            next_prdata[LCM_ST_REG_BIT] = reg_out;
            next_prdata[LCM_ST_COMB_BIT] = comb_out;
            next_prdata[LCM_ST_CARRY_BIT] = carry_out;
            next_prdata[LCM_ST_CASC_BIT] = cascade_out;
            next_prdata[LCM_ST_MODE_LSB +: 2] = ctrl[LCM_MODE_LSB +: 2];
          end
          default: begin
            next_prdata = 32'h0000_0000;
          end
        endcase
      end
    end
    // Writes land only at the sampled handshake edge
    if (wr_fire) begin
      case (paddr)
        LCM_CTRL_OFS: begin
          next_ctrl = pwdata[LCM_CTRL_W-1:0];
        end
        LCM_TABLE_OFS: begin
          next_table_mask = pwdata[LCM_TABLE_W-1:0];
        end
        default: begin
          // Status is read-only; unmapped writes are dropped
          next_ctrl = ctrl;
        end
      endcase
    end
  end

  // Register the bus state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= LCM_CTRL_RST;
      table_mask <= LCM_TABLE_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      table_mask <= next_table_mask;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cell datapath
  logic [3:0] norm_idx;   // Index into the four-input table
  logic [2:0] arith_idx;  // Index shared by both three-input tables
  logic table_out;        // Table result before the cascade
  logic casc_res;         // Result after the cascade join
  logic carry_res;        // Carry toward the next cell
  logic reg_d;            // Data the register takes in plain use
  logic next_carry_out;
  logic next_cascade_out;
  logic next_comb_out;
  logic next_reg_out;

  always_comb begin
    // Third table input: data or carry-in, per configuration
    norm_idx = {fourth_table_in, (cin_sel ? carry_in : third_table_in),
                second_operand_in, first_operand_in};
    arith_idx = {carry_in, second_operand_in, first_operand_in};
    table_out = 1'b0;
    carry_res = 1'b0;
    case (mode)
      LCM_NORMAL: begin
        table_out = table_mask[norm_idx];
      end
      LCM_ARITH: begin
        table_out = table_mask[{1'b0, arith_idx}];
        carry_res = table_mask[LCM_CARRY_LSB + {1'b0, arith_idx}];
      end
      LCM_COUNTER: begin
        // One counter bit; the carry ripples along the chain
        table_out = reg_out ^ carry_in;
        carry_res = third_table_in ? (!reg_out && carry_in)
                                   : (reg_out && carry_in);
      end
      default: begin
        table_out = 1'b0;
      end
    endcase
    // Cascade join is kept out of counter mode to protect the count
    if (casc_en && mode != LCM_COUNTER) begin
      casc_res = casc_or ? (table_out || cascade_in)
                         : (table_out && cascade_in);
    end else begin
      casc_res = table_out;
    end
    // Packed register follows its own input, table stays free
    reg_d = (packed_reg && mode == LCM_NORMAL) ? fourth_table_in
                                               : casc_res;
    next_carry_out = carry_res;
    next_cascade_out = casc_res;
    // Plain copy is registered on every clock, free of the enable
    next_comb_out = casc_res;
    next_reg_out = reg_out;
    // Clear over load over count, all gated by clock enable
    if (clock_enable_in) begin
      if (cluster_sync_clear) begin
        next_reg_out = 1'b0;
      end else if (cluster_sync_load) begin
        next_reg_out = first_operand_in;
      end else if (mode == LCM_COUNTER) begin
        if (second_operand_in) begin
          next_reg_out = table_out;
        end
      end else begin
        next_reg_out = reg_d;
      end
    end
  end

  // Register the cell outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      carry_out <= 1'b0;
      cascade_out <= 1'b0;
      comb_out <= 1'b0;
      reg_out <= 1'b0;
    end else begin
      carry_out <= next_carry_out;
      cascade_out <= next_cascade_out;
      comb_out <= next_comb_out;
      reg_out <= next_reg_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_lut_normal_read: assert property (
    (mode == LCM_NORMAL && !casc_en) |=> comb_out == $past(table_mask[{fourth_table_in,
      (cin_sel ? carry_in : third_table_in), second_operand_in, first_operand_in}]))
    else $error("normal table output wrong");

  a_cascade_and_join: assert property (
    (mode == LCM_NORMAL && casc_en && !casc_or && !cascade_in) |=> !cascade_out)
    else $error("cascade AND join wrong");

  a_packed_reg_path: assert property (
    (mode == LCM_NORMAL && packed_reg && clock_enable_in && !cluster_sync_clear
      && !cluster_sync_load) |=> reg_out == $past(fourth_table_in))
    else $error("packed register path wrong");

  a_arith_sum_table: assert property (
    (mode == LCM_ARITH && !casc_en) |=>
      comb_out == $past(table_mask[{1'b0, carry_in, second_operand_in, first_operand_in}]))
    else $error("arithmetic sum wrong");

  a_arith_carry_out: assert property (
    (mode == LCM_ARITH) |=>
      carry_out == $past(table_mask[{1'b1, carry_in, second_operand_in, first_operand_in}]))
    else $error("arithmetic carry wrong");

  a_arith_cascade_or: assert property (
    (mode == LCM_ARITH && casc_en && casc_or && cascade_in) |=> cascade_out)
    else $error("arithmetic cascade OR wrong");

  a_arith_dual_copy: assert property (
    (mode == LCM_ARITH && clock_enable_in && !cluster_sync_clear
      && !cluster_sync_load) |=> reg_out == comb_out)
    else $error("registered and plain sum differ");

  a_count_step: assert property (
    (mode == LCM_COUNTER && clock_enable_in && !cluster_sync_clear
      && !cluster_sync_load && second_operand_in) |=>
      reg_out == ($past(reg_out) ^ $past(carry_in)))
    else $error("counter step wrong");

  a_count_direction: assert property (
    (mode == LCM_COUNTER && third_table_in && carry_in && !reg_out) |=> carry_out)
    else $error("down count borrow missing");

  a_clear_beats_load: assert property (
    (clock_enable_in && cluster_sync_clear) |=> !reg_out)
    else $error("cluster clear ignored");

  a_hold_without_ce: assert property (
    !clock_enable_in |=> $stable(reg_out))
    else $error("register moved without enable");

  a_load_over_count: assert property (
    (clock_enable_in && !cluster_sync_clear && cluster_sync_load) |=>
      reg_out == $past(first_operand_in))
    else $error("cluster load wrong");

  a_apb_one_wait: assert property (
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("bus answer timing wrong");

  // Unmapped places answer with the error flag in the ready cycle
  a_bus_unmapped_err: assert property (
    (psel && penable && !pready && paddr != LCM_CTRL_OFS && paddr != LCM_TABLE_OFS
      && paddr != LCM_STATUS_OFS) |=> pready && pslverr)
    else $error("unmapped access not refused");

  // A control write lands at the handshake edge, not before
  a_ctrl_write_lands: assert property (
    (psel && penable && pready && pwrite && paddr == LCM_CTRL_OFS) |=>
      ctrl == $past(pwdata[LCM_CTRL_W-1:0]))
    else $error("control write lost");

  // Spare code keeps table and carry paths silent
  a_spare_mode_quiet: assert property (
    (mode == LCM_SPARE && !casc_en) |=> !carry_out && !comb_out)
    else $error("spare mode drives outputs");

endmodule : lcm_logic_cell

`default_nettype wire

// file: lcm_cluster_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Neighbour cells and shared cluster controls facing one cell
module lcm_cluster_model (
  output logic carry_in,
  output logic cascade_in,
  output logic cluster_sync_clear,
  output logic cluster_sync_load
);
  // Chains and cluster controls idle low
  initial begin
    carry_in = 1'b0;
    cascade_in = 1'b0;
    cluster_sync_clear = 1'b0;
    cluster_sync_load = 1'b0;
  end
  // Shared clear and load reach every register of the cluster together;
  // the other cells only join this counter or stay combinational
  task automatic drive(input logic [3:0] v);
    {cluster_sync_load, cluster_sync_clear, cascade_in, carry_in} <= v;
  endtask : drive
endmodule : lcm_cluster_model
`default_nettype wire

// file: logic_element_modes_tb.sv
`timescale 1ns/1ps
`default_nettype none
module logic_element_modes_tb;
  import lcm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [4:0] din = 5'h00; // Local inputs {ce, d4, d3, d2, d1}
  logic carry_in, cascade_in, sclr, sld;
  logic carry_out, cascade_out, comb_out, reg_out;
  logic [31:0] rd; // Last read data
  logic er; // Last error flag
  int n_errors = 0;
  int checks = 0;

  // 25 MHz clock
  always #20 clk = ~clk;

  lcm_cluster_model fab (.carry_in(carry_in), .cascade_in(cascade_in),
    .cluster_sync_clear(sclr), .cluster_sync_load(sld));

  lcm_logic_cell dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .first_operand_in(din[0]),
    .second_operand_in(din[1]), .third_table_in(din[2]), .fourth_table_in(din[3]),
    .carry_in(carry_in), .cascade_in(cascade_in), .clock_enable_in(din[4]),
    .cluster_sync_clear(sclr), .cluster_sync_load(sld), .carry_out(carry_out),
    .cascade_out(cascade_out), .comb_out(comb_out), .reg_out(reg_out));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    // Bounded wait; a hang ends the run
    if (pready !== 1'b1) begin
      n_errors++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Inputs live for one edge only, then idle with the enable low,
  // so a counter step is never applied twice
  task automatic step(input logic [8:0] v); // {ld,clr,casc,cin,ce,d4,d3,d2,d1}
    @(posedge clk);
    din <= v[4:0];
    fab.drive(v[8:5]);
    @(posedge clk);
    din <= 5'h00;
    fab.drive(4'h0);
    #1;
  endtask : step

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, read-back, unmapped and read-only places
  task automatic t_bus;
    chk("reg_out", reg_out, 32'h00000000);
    apb(1'b0, LCM_CTRL_OFS, 32'h00000000);
    chk("ctrl", rd, 32'h00000000);
    apb(1'b1, LCM_TABLE_OFS, 32'hFFFF1234);
    apb(1'b0, LCM_TABLE_OFS, 32'h00000000);
    chk("table", rd, 32'h00001234);
    apb(1'b0, 12'h00C, 32'h00000000);
    chk("unmapped", {rd[30:0], er}, 32'h00000001);
    apb(1'b1, LCM_STATUS_OFS, 32'h00000030);
    chk("status_wr", {rd[30:0], er}, 32'h00000000);
    apb(1'b0, LCM_CTRL_OFS, 32'h00000000);
    chk("ctrl_kept", rd, 32'h00000000);
    $display("bus test done");
  endtask : t_bus

  // Normal mode: every input, both select and join settings
  task automatic t_normal;
    int i, s;
    logic lut, ci, jn;
    logic [15:0] tbl = 16'hA5C3;
    apb(1'b1, LCM_TABLE_OFS, {16'h0000, tbl});
    for (s = 0; s < 8; s++) begin
      // Third input select, join kind, cascade on or off
      apb(1'b1, LCM_CTRL_OFS, {26'h0000000, s[1], 1'b1, !s[2], s[0], 2'b00});
      for (i = 0; i < 32; i++) begin
        ci = i[2] ^ i[4];
        step({2'b00, ci, i[4], 1'b1, i[3:0]});
        lut = tbl[{i[3], s[0] ? i[4] : i[2], i[1:0]}];
        // Both outputs carry the joined value while the chain is on
        jn = s[2] ? lut : (s[1] ? (lut | ci) : (lut & ci));
        chk("comb_out", comb_out, jn);
        chk("cascade_out", cascade_out, jn);
        chk("packed", reg_out, i[3]);
      end
    end
    $display("normal test done");
  endtask : t_normal

  // Arithmetic mode as a full adder, cascade joined by OR
  task automatic t_arith;
    int i;
    logic s, c;
    apb(1'b1, LCM_TABLE_OFS, 32'h0000E896);
    apb(1'b1, LCM_CTRL_OFS, 32'h00000029);
    for (i = 0; i < 16; i++) begin
      step({2'b00, i[3], i[2], 1'b1, 2'b00, i[1:0]});
      s = i[0] ^ i[1] ^ i[2];
      c = (i[0] & i[1]) | (i[2] & (i[0] | i[1]));
      chk("sum", comb_out, s | i[3]);
      chk("carry_out", carry_out, c);
      chk("cascade_out", cascade_out, s | i[3]);
      chk("sum_reg", reg_out, s | i[3]);
    end
    // Enable low: live copy moves, registered copy holds
    step(9'h003);
    chk("sum", comb_out, 32'h00000000);
    chk("sum_reg", reg_out, 32'h00000001);
    // Spare code: table and carry paths stay low
    apb(1'b1, LCM_CTRL_OFS, 32'h00000003);
    step(9'h03F);
    chk("spare_comb", comb_out, 32'h00000000);
    chk("spare_carry", carry_out, 32'h00000000);
    $display("arith test done");
  endtask : t_arith

  // Counter: enable, count, direction, clear, load, priority
  task automatic t_counter;
    int i;
    logic q = 1'b0;
    logic cx;
    logic [8:0] seq [8] = '{9'h111, 9'h080, 9'h191, 9'h032, 9'h030, 9'h036,
                             9'h132, 9'h036};
    apb(1'b1, LCM_CTRL_OFS, 32'h00000002);
    for (i = 0; i < 8; i++) begin
      step(seq[i]);
      // Carry: up passes on a set bit, down passes on a clear bit
      cx = seq[i][5] & (seq[i][2] ? !q : q);
      chk("count_carry", carry_out, cx);
      // Clear over load over count, all held off by the enable
      if (seq[i][4]) begin
        q = seq[i][7] ? 1'b0 : seq[i][8] ? seq[i][0] : q ^ (seq[i][1] & seq[i][5]);
      end
      chk("count", reg_out, q);
    end
    apb(1'b0, LCM_STATUS_OFS, 32'h00000000);
    chk("status", rd & 32'h00000031, 32'h00000020 | q);
    $display("counter test done");
  endtask : t_counter

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_bus();
    t_normal();
    t_arith();
    t_counter();
    test_done();
  end
endmodule : logic_element_modes_tb
`default_nettype wire
